// ### rtl/cmdseq_regs.svh
// Register map, field positions and codes of the fast command sequencer.
// Assumes a 16-bit byte address on the register port and 32-bit data words.
`ifndef CMDSEQ_REGS_SVH
`define CMDSEQ_REGS_SVH

// -----------------------------------------------------------------------
// Global registers
// -----------------------------------------------------------------------
`define TRIG_CTRL_OFS 16'h0000
`define TRIG_TIMING_OFS 16'h0004
`define TRIG_RATE_OFS 16'h0008
`define ASYNC_SHORT_OFS 16'h000c
`define ASYNC_LONG_HI_OFS 16'h0010
`define ASYNC_LONG_LO_OFS 16'h0014
`define EVENT_CNT_OFS 16'h0018
`define ORBIT_CNT_OFS 16'h001c
`define STATUS_OFS 16'h0020

// -----------------------------------------------------------------------
// Per-channel block: base + channel * 32 + offset
// -----------------------------------------------------------------------
`define CH_BASE 16'h0100
`define CH_STRIDE_LOG2 5
`define CH_CFG_OFS 16'h0000
`define CH_TIMING_OFS 16'h0004
`define CH_GO_OFS 16'h0008
`define CH_LOAD_SHORT_OFS 16'h000c
`define CH_LOAD_LONG_OFS 16'h0010
`define CH_STATUS_OFS 16'h0014

// -----------------------------------------------------------------------
// Fields and codes
// -----------------------------------------------------------------------
`define CTRL_CNT_SEND_BIT 2
`define CTRL_CNT_SEL_BIT 3
`define TIM_HI_LSB 16
`define LOAD_NOP_BIT 8
`define GO_SRC_EXT 2'h0
`define GO_SRC_ORBIT 2'h1
`define GO_SRC_BUS 2'h2
`define ENTRY_SHORT 2'h0
`define ENTRY_LONG 2'h1
`define ENTRY_NOP 2'h2
`define TRIG_OFF 2'h0
`define TRIG_ORBIT 2'h1
`define TRIG_RANDOM 2'h2
`define TRIG_MIN_GAP 8'h03
`define LFSR_SEED 16'hace1

`endif

// ### rtl/cmdseq_pkg.sv
// Types carried between the parts of the fast command sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package cmdseq_pkg;

  // -----------------------------------------------------------------------
  // Channel types
  // -----------------------------------------------------------------------
  typedef enum logic [2:0] {CH_IDLE, CH_DELAY, CH_HOLD, CH_READY, CH_SEND} ch_phase_t;

  // Layout equals bits [8:0] of a config write
  typedef struct packed {
    logic [2:0] pattern;
    logic enc_a;
    logic block;
    logic repeat_en;
    logic double_en;
    logic [1:0] go_src;
  } ch_cfg_t;

  typedef struct packed {
    logic [7:0] hold;
    logic [11:0] delay;
  } ch_timing_t;

  typedef struct packed {
    ch_phase_t phase;
    logic second;
    logic block_run;
    logic [11:0] cnt;
  } ch_run_t;

  // -----------------------------------------------------------------------
  // Queue entry and channel B command
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] kind;
    logic [31:0] data;
  } q_entry_t;

  typedef struct packed {
    logic is_long;
    logic broadcast;
    logic [31:0] data;
  } b_cmd_t;

endpackage : cmdseq_pkg

// ### rtl/fast_command_sequencer.sv
// Fast command sequencer: per-channel command queues, hold-off timing,
// channel B command issue, channel A patterns and internal triggers.
// Assumes go, trigger and orbit inputs are asynchronous pins and the
// channel B encoder and register master share this clock.
// NUM_CH and QDEPTH must be powers of two, NUM_CH between 2 and 16.
`include "cmdseq_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module fast_command_sequencer #(
  parameter int NUM_CH = 16,
  parameter int QDEPTH = 16384
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic [3:0] go_code,
  input wire logic go_strobe,
  input wire logic trigger_accept_in,
  input wire logic orbit_in,
  input wire logic b_ready,
  output cmdseq_pkg::b_cmd_t b_cmd,
  output logic b_valid,
  output logic chan_a
);

  localparam int CW = $clog2(NUM_CH);
  localparam int PW = $clog2(QDEPTH);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    cmdseq_pkg::ch_run_t [NUM_CH-1:0] run;
    cmdseq_pkg::ch_cfg_t [NUM_CH-1:0] cfg;
    cmdseq_pkg::ch_timing_t [NUM_CH-1:0] tim;
    logic [NUM_CH-1:0][PW:0] rd;
    logic [NUM_CH-1:0][PW:0] wr;
    logic [6:0] s1;
    logic [6:0] s2;
    logic orbit_d;
    cmdseq_pkg::b_cmd_t b_cmd;
    logic b_valid;
    logic b_from_ch;
    logic [CW-1:0] b_owner;
    logic [2:0] a_shift;
    logic [1:0] a_cnt;
    logic a_bit;
    logic [1:0] trig_mode;
    logic cnt_send;
    logic cnt_sel;
    logic [11:0] trig_delay;
    logic [7:0] prescale;
    logic [15:0] rate;
    logic [7:0] presc_cnt;
    logic [11:0] tdly_cnt;
    logic tdly_run;
    logic [15:0] lfsr;
    logic [7:0] gap;
    logic cnt_pend;
    logic short_pend;
    logic [7:0] short_data;
    logic long_pend;
    logic [15:0] long_hi;
    logic [31:0] long_data;
    logic [31:0] event_cnt;
    logic [31:0] orbit_cnt;
    logic [31:0] rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // Queue storage, one region of QDEPTH entries per channel
  cmdseq_pkg::q_entry_t mem [0:NUM_CH*QDEPTH-1];
  logic mem_we;
  logic [CW+PW-1:0] mem_wa;
  cmdseq_pkg::q_entry_t mem_wd;

  logic orbit_pulse;
  logic b_done;
  logic blocking;
  logic started;
  logic go;
  logic bus_go;
  logic pat_req;
  logic [2:0] pat;
  logic pat_busy;
  logic int_fire;
  logic trig_out;
  logic [PW:0] nrd;
  cmdseq_pkg::q_entry_t ent;
  logic [15:0] busy;

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  // Address match for one register of one channel
  function automatic logic ch_hit(input logic [15:0] a, input logic [15:0] ofs, input int ch);
    logic [15:0] base;
    base = `CH_BASE + 16'(ch << `CH_STRIDE_LOG2);
    return a == base + ofs;
  endfunction : ch_hit

  // End of one transmission cycle: second cycle or back to idle
  function automatic cmdseq_pkg::ch_run_t cycle_end(input cmdseq_pkg::ch_run_t r,
      input cmdseq_pkg::ch_cfg_t c, input cmdseq_pkg::ch_timing_t t);
    cmdseq_pkg::ch_run_t o;
    o = r;
    if (c.double_en && !r.second) begin
      o.phase = cmdseq_pkg::CH_DELAY;
      o.cnt = t.delay;
      o.second = 1'b1;
    end else begin
      o.phase = cmdseq_pkg::CH_IDLE;
    end
    return o;
  endfunction : cycle_end

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    pat_req = 1'b0;
    pat = 3'h0;
    started = 1'b0;
    blocking = 1'b0;
    go = 1'b0;
    bus_go = 1'b0;
    nrd = '0;
    ent = '0;
    busy = 16'h0000;
    // Pins pass two flops; only the second stage is used below
    s_nxt.s1 = {go_code, go_strobe, trigger_accept_in, orbit_in};
    s_nxt.s2 = s_r.s1;
    s_nxt.orbit_d = s_r.s2[0];
    orbit_pulse = s_r.s2[0] & ~s_r.orbit_d;
    s_nxt.rdata = 32'h0000_0000;
    b_done = s_r.b_valid & b_ready;
    if (b_done) begin
      s_nxt.b_valid = 1'b0;
    end

    for (int i = 0; i < NUM_CH; i++) begin
      bus_go = wr_stb && ch_hit(addr, `CH_GO_OFS, i);
      // Go source selection
      case (s_r.cfg[i].go_src)
        `GO_SRC_EXT: go = s_r.s2[2] && s_r.s2[6:3] == 4'(i);
        `GO_SRC_ORBIT: go = orbit_pulse;
        `GO_SRC_BUS: go = bus_go || s_r.run[i].block_run;
        default: go = 1'b0;
      endcase
      if (bus_go && s_r.cfg[i].block && s_r.cfg[i].go_src == `GO_SRC_BUS) begin
        s_nxt.run[i].block_run = 1'b1;
      end
      // Channel sequencing
      case (s_r.run[i].phase)
        cmdseq_pkg::CH_IDLE: begin
          if (go) begin
            s_nxt.run[i].phase = cmdseq_pkg::CH_DELAY;
            s_nxt.run[i].cnt = s_r.tim[i].delay;
            s_nxt.run[i].second = 1'b0;
          end
        end
        cmdseq_pkg::CH_DELAY: begin
          if (s_r.run[i].cnt == 12'h000) begin
            s_nxt.run[i].phase = cmdseq_pkg::CH_HOLD;
            s_nxt.run[i].cnt = {4'h0, s_r.tim[i].hold};
          end else begin
            s_nxt.run[i].cnt = s_r.run[i].cnt - 12'h001;
          end
        end
        cmdseq_pkg::CH_HOLD: begin
          if (s_r.run[i].cnt == 12'h000) begin
            s_nxt.run[i].phase = cmdseq_pkg::CH_READY;
            if (!s_r.run[i].second && s_r.cfg[i].enc_a && !pat_req) begin
              pat_req = 1'b1;
              pat = s_r.cfg[i].pattern;
            end
          end else begin
            s_nxt.run[i].cnt = s_r.run[i].cnt - 12'h001;
          end
        end
        cmdseq_pkg::CH_READY: begin
          // Waits while a lower-numbered channel holds off or channel B is busy
          if (!blocking && !started && !s_r.b_valid) begin
            started = 1'b1;
            if (s_r.rd[i] == s_r.wr[i]) begin
              s_nxt.run[i].phase = cmdseq_pkg::CH_IDLE;
              s_nxt.run[i].block_run = 1'b0;
            end else begin
              ent = mem[{CW'(i), s_r.rd[i][PW-1:0]}];
              nrd = s_r.rd[i] + 1'b1;
              if (nrd == s_r.wr[i]) begin
                s_nxt.run[i].block_run = 1'b0;
                if (s_r.cfg[i].repeat_en) begin
                  nrd = '0;
                end
              end
              s_nxt.rd[i] = nrd;
              if (ent.kind == `ENTRY_NOP) begin
                s_nxt.run[i] = cycle_end(s_nxt.run[i], s_r.cfg[i], s_r.tim[i]);
              end else begin
                s_nxt.b_cmd.is_long = ent.kind == `ENTRY_LONG;
                s_nxt.b_cmd.broadcast = ent.kind != `ENTRY_LONG || ent.data[31:18] == 14'h0000;
                s_nxt.b_cmd.data = ent.data;
                s_nxt.b_valid = 1'b1;
                s_nxt.b_from_ch = 1'b1;
                s_nxt.b_owner = CW'(i);
                s_nxt.run[i].phase = cmdseq_pkg::CH_SEND;
              end
            end
          end
        end
        cmdseq_pkg::CH_SEND: begin
          if (b_done && s_r.b_from_ch && s_r.b_owner == CW'(i)) begin
            s_nxt.run[i] = cycle_end(s_nxt.run[i], s_r.cfg[i], s_r.tim[i]);
          end
        end
        default: s_nxt.run[i].phase = cmdseq_pkg::CH_IDLE;
      endcase
      if (s_r.run[i].phase == cmdseq_pkg::CH_HOLD || s_r.run[i].phase == cmdseq_pkg::CH_READY) begin
        blocking = 1'b1;
      end
      busy[i] = s_r.run[i].phase != cmdseq_pkg::CH_IDLE;
      // Channel register writes win over sequencing
      if (wr_stb && ch_hit(addr, `CH_CFG_OFS, i)) begin
        s_nxt.cfg[i] = wdata[8:0];
        s_nxt.run[i] = '0;
        s_nxt.rd[i] = '0;
        s_nxt.wr[i] = '0;
      end
      if (wr_stb && ch_hit(addr, `CH_TIMING_OFS, i)) begin
        s_nxt.tim[i] = {wdata[`TIM_HI_LSB +: 8], wdata[11:0]};
      end
      // Full queue drops further loads
      if (wr_stb && s_r.wr[i] != (PW+1)'(QDEPTH)) begin
        if (ch_hit(addr, `CH_LOAD_SHORT_OFS, i) || ch_hit(addr, `CH_LOAD_LONG_OFS, i)) begin
          mem_we = 1'b1;
          mem_wa = {CW'(i), s_r.wr[i][PW-1:0]};
          mem_wd.data = wdata;
          mem_wd.kind = ch_hit(addr, `CH_LOAD_LONG_OFS, i) ? `ENTRY_LONG :
                        wdata[`LOAD_NOP_BIT] ? `ENTRY_NOP : `ENTRY_SHORT;
          if (mem_wd.kind != `ENTRY_LONG) begin
            mem_wd.data = {24'h000000, wdata[7:0]};
          end
          s_nxt.wr[i] = s_r.wr[i] + 1'b1;
        end
      end
      if (rd_stb && ch_hit(addr, `CH_CFG_OFS, i)) begin
        s_nxt.rdata = {23'h000000, s_r.cfg[i]};
      end
      if (rd_stb && ch_hit(addr, `CH_TIMING_OFS, i)) begin
        s_nxt.rdata = {8'h00, s_r.tim[i].hold, 4'h0, s_r.tim[i].delay};
      end
      if (rd_stb && ch_hit(addr, `CH_STATUS_OFS, i)) begin
        s_nxt.rdata = {16'(s_r.rd[i]), 16'(s_r.wr[i])};
      end
    end

    // Queued channels come first; counter, then asynchronous commands fill gaps
    if (!s_r.b_valid && !started) begin
      if (s_r.cnt_pend) begin
        s_nxt.b_cmd = {1'b1, 1'b1, s_r.cnt_sel ? s_r.orbit_cnt : s_r.event_cnt};
        s_nxt.b_valid = 1'b1;
        s_nxt.b_from_ch = 1'b0;
        s_nxt.cnt_pend = 1'b0;
      end else if (s_r.short_pend) begin
        s_nxt.b_cmd = {1'b0, 1'b1, 24'h000000, s_r.short_data};
        s_nxt.b_valid = 1'b1;
        s_nxt.b_from_ch = 1'b0;
        s_nxt.short_pend = 1'b0;
      end else if (s_r.long_pend) begin
        s_nxt.b_cmd.is_long = 1'b1;
        s_nxt.b_cmd.broadcast = s_r.long_data[31:18] == 14'h0000;
        s_nxt.b_cmd.data = s_r.long_data;
        s_nxt.b_valid = 1'b1;
        s_nxt.b_from_ch = 1'b0;
        s_nxt.long_pend = 1'b0;
      end
    end

    // Channel A: pattern shifts out MSB first, else trigger accepts
    pat_busy = s_r.a_cnt != 2'h0 || pat_req;
    int_fire = 1'b0;
    s_nxt.lfsr = s_r.lfsr == 16'h0000 ? `LFSR_SEED :
                 {s_r.lfsr[14:0], s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10]};
    if (s_r.trig_mode == `TRIG_ORBIT) begin
      if (orbit_pulse) begin
        if (s_r.presc_cnt + 8'h01 >= s_r.prescale) begin
          s_nxt.presc_cnt = 8'h00;
          s_nxt.tdly_run = 1'b1;
          s_nxt.tdly_cnt = s_r.trig_delay;
        end else begin
          s_nxt.presc_cnt = s_r.presc_cnt + 8'h01;
        end
      end
      if (s_r.tdly_run) begin
        if (s_r.tdly_cnt == 12'h000) begin
          int_fire = 1'b1;
          s_nxt.tdly_run = 1'b0;
        end else begin
          s_nxt.tdly_cnt = s_r.tdly_cnt - 12'h001;
        end
      end
    end else if (s_r.trig_mode == `TRIG_RANDOM) begin
      int_fire = s_r.lfsr < s_r.rate && s_r.gap == 8'h00;
    end
    // A blocked internal trigger is dropped, not deferred
    trig_out = !pat_busy && (s_r.s2[1] || int_fire);
    if (s_r.gap != 8'h00) begin
      s_nxt.gap = s_r.gap - 8'h01;
    end
    if (s_r.a_cnt != 2'h0) begin
      s_nxt.a_bit = s_r.a_shift[2];
      s_nxt.a_shift = {s_r.a_shift[1:0], 1'b0};
      s_nxt.a_cnt = s_r.a_cnt - 2'h1;
    end else if (pat_req) begin
      s_nxt.a_bit = pat[2];
      s_nxt.a_shift = {pat[1:0], 1'b0};
      s_nxt.a_cnt = 2'h2;
    end else begin
      s_nxt.a_bit = trig_out;
    end
    if (trig_out) begin
      s_nxt.gap = `TRIG_MIN_GAP;
      s_nxt.event_cnt = s_r.event_cnt + 32'h0000_0001;
      if (s_r.cnt_send) begin
        s_nxt.cnt_pend = 1'b1;
      end
    end
    if (orbit_pulse) begin
      s_nxt.orbit_cnt = s_r.orbit_cnt + 32'h0000_0001;
    end

    // Global register writes, after the loaders so a new request wins
    if (wr_stb) begin
      case (addr)
        `TRIG_CTRL_OFS: begin
          s_nxt.trig_mode = wdata[1:0];
          s_nxt.cnt_send = wdata[`CTRL_CNT_SEND_BIT];
          s_nxt.cnt_sel = wdata[`CTRL_CNT_SEL_BIT];
          s_nxt.tdly_run = 1'b0;
          s_nxt.presc_cnt = 8'h00;
        end
        `TRIG_TIMING_OFS: begin
          s_nxt.trig_delay = wdata[11:0];
          s_nxt.prescale = wdata[`TIM_HI_LSB +: 8];
        end
        `TRIG_RATE_OFS: s_nxt.rate = wdata[15:0];
        `ASYNC_SHORT_OFS: begin
          s_nxt.short_data = wdata[7:0];
          s_nxt.short_pend = 1'b1;
        end
        `ASYNC_LONG_HI_OFS: s_nxt.long_hi = wdata[15:0];
        `ASYNC_LONG_LO_OFS: begin
          s_nxt.long_data = {s_r.long_hi, wdata[15:0]};
          s_nxt.long_pend = 1'b1;
        end
        default: ;
      endcase
    end
    if (rd_stb) begin
      case (addr)
        `TRIG_CTRL_OFS: s_nxt.rdata = {28'h0000000, s_r.cnt_sel, s_r.cnt_send, s_r.trig_mode};
        `TRIG_TIMING_OFS: s_nxt.rdata = {8'h00, s_r.prescale, 4'h0, s_r.trig_delay};
        `TRIG_RATE_OFS: s_nxt.rdata = {16'h0000, s_r.rate};
        `EVENT_CNT_OFS: s_nxt.rdata = s_r.event_cnt;
        `ORBIT_CNT_OFS: s_nxt.rdata = s_r.orbit_cnt;
        `STATUS_OFS: s_nxt.rdata = {11'h000, s_r.b_valid, s_r.a_cnt != 2'h0, s_r.cnt_pend,
                                    s_r.short_pend, s_r.long_pend, busy};
        default: ;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Queue storage has no reset; pointers define what is valid
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Outputs straight from flops
  assign rdata = s_r.rdata;
  assign b_cmd = s_r.b_cmd;
  assign b_valid = s_r.b_valid;
  assign chan_a = s_r.a_bit;

endmodule : fast_command_sequencer

`default_nettype wire

// ### test/fcs_asserts.sv
// Port-level checker for the fast command sequencer, bound to the design.
// Assumes the register map header is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "cmdseq_regs.svh"
module fcs_asserts #(
  parameter int NUM_CH = 16,
  parameter int QDEPTH = 16384
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rdata,
  input wire logic [3:0] go_code,
  input wire logic go_strobe,
  input wire logic trigger_accept_in,
  input wire logic orbit_in,
  input wire logic b_ready,
  input wire cmdseq_pkg::b_cmd_t b_cmd,
  input wire logic b_valid,
  input wire logic chan_a
);
  // ----------------------------------------------------------------
  // Port relations, single clock domain
  // ----------------------------------------------------------------
  default clocking dc @(posedge clock); endclocking
  default disable iff (!resetn);
  AST_B_HOLD: assert property (b_valid && !b_ready |=> b_valid && $stable(b_cmd))
    else $error("channel B command dropped before acceptance");
  AST_RD_ONE: assert property (rdata != 32'h0 |-> $past(rd_stb))
    else $error("read data outside its cycle");
  AST_UNMAPPED: assert property (rd_stb && addr == 16'h0080 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_SHORT_FMT: assert property (b_valid && !b_cmd.is_long |-> b_cmd.broadcast && b_cmd.data[31:8] == 24'h0)
    else $error("short command malformed");
  AST_LONG_BCAST: assert property (b_valid && b_cmd.is_long |-> b_cmd.broadcast == (b_cmd.data[31:18] == 14'h0))
    else $error("long broadcast flag wrong");
  AST_ASYNC_SHORT: assert property (wr_stb && addr == `ASYNC_SHORT_OFS && !b_valid |-> ##[1:2] b_valid)
    else $error("async short not issued");
  AST_ASYNC_LONG: assert property (wr_stb && addr == `ASYNC_LONG_LO_OFS && !b_valid |-> ##[1:2] b_valid)
    else $error("async long not issued");
  AST_RESET_QUIET: assert property ($rose(resetn) |-> !b_valid && !chan_a && rdata == 32'h0)
    else $error("outputs active right after reset");
endmodule : fcs_asserts
bind fast_command_sequencer fcs_asserts #(.NUM_CH(NUM_CH), .QDEPTH(QDEPTH)) u_chk (
  .clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .go_code(go_code), .go_strobe(go_strobe), .trigger_accept_in(trigger_accept_in),
  .orbit_in(orbit_in), .b_ready(b_ready), .b_cmd(b_cmd), .b_valid(b_valid), .chan_a(chan_a));
`default_nettype wire

// ### test/b_encoder_model.sv
// Channel B encoder model: takes commands promptly or with random stalls.
// Assumes the sequencer clock and the package command carrier.
`timescale 1ns/10ps
`default_nettype none
module b_encoder_model (
  input wire logic clock,
  input wire logic resetn,
  input wire cmdseq_pkg::b_cmd_t b_cmd,
  input wire logic b_valid,
  input wire logic slow,
  output var logic b_ready,
  output var logic taken,
  output var cmdseq_pkg::b_cmd_t taken_cmd
);
  // ----------------------------------------------------------------
  // Ready with optional stalls, report of each accepted command
  // ----------------------------------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      b_ready <= 1'b0;
      taken <= 1'b0;
      taken_cmd <= '0;
    end else begin
      taken <= b_valid && b_ready;
      taken_cmd <= b_cmd;
      // Slow encoder is busy framing three cycles in four
      b_ready <= !slow || ($urandom % 4 == 0);
    end
  end
endmodule : b_encoder_model
`default_nettype wire

// ### test/fast_command_sequencer_tb.sv
// Testbench: queues, async commands, hold-off timing, patterns, triggers.
// Assumes the package, design, checker and encoder model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "cmdseq_regs.svh"
module fast_command_sequencer_tb;
  logic clock, resetn, wr_stb, rd_stb, go_strobe, orbit_in, slow, b_ready, b_valid, chan_a, taken, trig_in;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, w;
  logic [3:0] go_code;
  logic [7:0] d8;
  logic [2:0] pat;
  cmdseq_pkg::b_cmd_t b_cmd, taken_cmd;
  cmdseq_pkg::b_cmd_t rx[$];
  int errors, total_checks, n0, n1, hits, h0, dl, ho;

  fast_command_sequencer #(.NUM_CH(16), .QDEPTH(16)) dut (
    .clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .go_code(go_code), .go_strobe(go_strobe), .trigger_accept_in(trig_in),
    .orbit_in(orbit_in), .b_ready(b_ready), .b_cmd(b_cmd), .b_valid(b_valid), .chan_a(chan_a));
  b_encoder_model enc (
    .clock(clock), .resetn(resetn), .b_cmd(b_cmd), .b_valid(b_valid), .slow(slow),
    .b_ready(b_ready), .taken(taken), .taken_cmd(taken_cmd));

  // ----------------------------------------------------------------
  // Clock, collectors and helpers
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    if (taken) rx.push_back(taken_cmd);
    if (chan_a) hits++;
  end
  function automatic cmdseq_pkg::b_cmd_t mk(input logic lng, input logic [31:0] d);
    mk = '{is_long: lng, broadcast: !lng || d[31:18] == 14'h0, data: d};
  endfunction : mk
  function automatic logic [15:0] cb(input int ch);
    cb = `CH_BASE + 16'(ch << `CH_STRIDE_LOG2);
  endfunction : cb
  task automatic conclude();
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Master changes everything just after the edge, one-cycle strobes
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd
  task automatic go(input int ch);
    wr(cb(ch) + `CH_GO_OFS, 32'h0);
  endtask : go
  task automatic ld(input int ch, input logic [31:0] d);
    wr(cb(ch) + `CH_LOAD_SHORT_OFS, d);
  endtask : ld
  task automatic expect_b(input cmdseq_pkg::b_cmd_t e, input logic [33:0] m = '1);
    for (int i = 0; i < 3000 && rx.size() == 0; i++) @(posedge clock);
    if (rx.size() == 0) begin
      errors++;
      conclude();
    end else chk(rx.pop_front() & m, e & m);
  endtask : expect_b
  task automatic quiet(input int n);
    repeat (n) @(posedge clock);
    chk(34'(rx.size()), 34'h0);
  endtask : quiet
  task automatic orbit();
    @(posedge clock);
    orbit_in <= 1'b1;
    repeat (2) @(posedge clock);
    orbit_in <= 1'b0;
    repeat (40) @(posedge clock);
  endtask : orbit
  initial begin
    #10000000;
    errors++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    addr = 16'h0;
    wdata = 32'h0;
    {wr_stb, rd_stb, go_strobe, orbit_in, slow, trig_in} = 6'h0;
    go_code = 4'h0;
    void'($urandom(81));
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    // Async commands against a stalling encoder
    slow <= 1'b1;
    d8 = 8'($urandom);
    wr(`ASYNC_SHORT_OFS, {24'h0, d8});
    expect_b(mk(1'b0, {24'h0, d8}));
    for (int i = 0; i < 2; i++) begin
      w = $urandom;
      if (i == 0) w[31:18] = 14'h0;
      else w[31] = 1'b1;
      wr(`ASYNC_LONG_HI_OFS, {16'h0, w[31:16]});
      wr(`ASYNC_LONG_LO_OFS, {16'h0, w[15:0]});
      expect_b(mk(1'b1, w));
    end
    // Bus single: short, no-op, long, then an empty queue
    wr(cb(1), 32'h2);
    ld(1, {24'h0, d8});
    ld(1, 32'h100);
    wr(cb(1) + `CH_LOAD_LONG_OFS, w);
    go(1);
    expect_b(mk(1'b0, {24'h0, d8}));
    go(1);
    quiet(40);
    go(1);
    expect_b(mk(1'b1, w));
    go(1);
    quiet(40);
    rd(cb(1) + `CH_STATUS_OFS, 32'h0003_0003);
    // Repetitive sequence wraps
    wr(cb(2), 32'ha);
    ld(2, 32'h10);
    ld(2, 32'h11);
    for (int i = 0; i < 4; i++) begin
      go(2);
      expect_b(mk(1'b0, 32'h10 + 32'(i % 2)));
    end
    // One go: block drains three, double sends two
    for (int m = 0; m < 2; m++) begin
      wr(cb(3 + m), m ? 32'h6 : 32'h12);
      for (int i = 0; i < 3; i++) ld(3 + m, 32'h20 + 32'(i));
      go(3 + m);
      for (int i = 0; i < 3 - m; i++) expect_b(mk(1'b0, 32'h20 + 32'(i)));
      quiet(80);
    end
    // External go code and orbit as go sources
    wr(cb(5), 32'h0);
    wr(cb(6), 32'h1);
    ld(5, 32'h30);
    ld(6, 32'h31);
    @(posedge clock);
    go_code <= 4'h5;
    go_strobe <= 1'b1;
    @(posedge clock);
    go_strobe <= 1'b0;
    expect_b(mk(1'b0, 32'h30));
    orbit();
    expect_b(mk(1'b0, 32'h31));
    // Hold-off timing relative to zero delay and hold
    slow <= 1'b0;
    wr(cb(0), 32'h2);
    for (int k = 0; k < 2; k++) begin
      dl = k ? $urandom % 16 : 0;
      ho = k ? $urandom % 16 : 0;
      wr(cb(0) + `CH_TIMING_OFS, {8'h0, 8'(ho), 4'h0, 12'(dl)});
      ld(0, 32'h40);
      go(0);
      #1;
      for (n1 = 0; n1 < 500 && !b_valid; n1++) begin
        @(posedge clock);
        #1;
      end
      if (k == 0) n0 = n1;
      expect_b(mk(1'b0, 32'h40));
    end
    chk(34'(n1 - n0), 34'(dl + ho));
    // Channel A patterns for each example code
    for (int p = 4; p < 8; p++) begin
      wr(cb(6), 32'(p << 6) | 32'h22);
      ld(6, 32'h50);
      go(6);
      #1;
      for (n1 = 0; n1 < 500 && !chan_a; n1++) begin
        @(posedge clock);
        #1;
      end
      for (int b = 2; b >= 0; b--) begin
        pat[b] = chan_a;
        @(posedge clock);
        #1;
      end
      chk(34'(pat), 34'(p));
      expect_b(mk(1'b0, 32'h50));
    end
    // Orbit triggers, every second orbit, event count sent after each
    wr(`TRIG_TIMING_OFS, 32'h0002_0005);
    wr(`TRIG_CTRL_OFS, 32'h5);
    h0 = hits;
    repeat (4) orbit();
    chk(34'(hits - h0), 34'h2);
    for (int i = 0; i < 2; i++) expect_b(mk(1'b1, 32'(i + 1)));
    wr(`TRIG_CTRL_OFS, 32'h0);
    rd(`EVENT_CNT_OFS, 32'h2);
    rd(`ORBIT_CNT_OFS, 32'h5);
    // Full-rate random triggers, spaced by the minimum gap, then one external accept
    h0 = hits;
    wr(`TRIG_RATE_OFS, 32'hffff);
    wr(`TRIG_CTRL_OFS, 32'h2);
    repeat (40) @(posedge clock);
    wr(`TRIG_CTRL_OFS, 32'h0);
    @(posedge clock);
    trig_in <= 1'b1;
    @(posedge clock);
    trig_in <= 1'b0;
    repeat (6) @(posedge clock);
    chk(34'(hits - h0), 34'(41 / (`TRIG_MIN_GAP + 1) + 2));
    wr(16'h0080, 32'hffff_ffff);
    rd(16'h0080, 32'h0);
    conclude();
  end
endmodule : fast_command_sequencer_tb
`default_nettype wire
